/* File: verilog/tsp_slave_port.sv */
`timescale 1ns/1ps
// How it works
// - Only fixed 7-bit address 0x12 is acknowledged.
// - Address with write bit, then pointer byte, are both acknowledged.
// - Each later byte is acknowledged, stored at pointer, pointer steps.
// - Read returns byte at pointer; each host ack sends next address.
// - Host NACK ends the read; host then sends stop.
// - After a read the pointer returns to last written pointer value.
// - Change line pulled low when masked key or input changes.
// - Reading both status bytes releases the change line.
// - If status returned to earlier value, any read releases it.
// - Line low with other line quiet past 14 ms resets bus logic.
// - Standalone operation disables the stuck-bus monitor.
// - Data low and clock high at start selects standalone.
// - Wake from low power waits 500 us before acquisition.
// - Lines are only pulled low or released, never driven high.
// - After soft reset no transfer is acknowledged for 30 ms.
module tsp_slave_port #(
    parameter int STUCK_CYCLES_P = tsp_pkg::STUCK_CYCLES,
    parameter int NACK_CYCLES_P = tsp_pkg::NACK_CYCLES,
    parameter int WAKE_CYCLES_P = tsp_pkg::WAKE_CYCLES
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Serial pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic change_notify_line_o,
    output logic change_notify_line_oe,
    // Table access and sensing state
    output tsp_pkg::tsp_mem_port_type mem,
    input wire logic [7:0] mem_rdata,
    input wire tsp_pkg::tsp_sense_type sense,
    output logic acquire_en
);
    tsp_pkg::tsp_top_state_type s;
    tsp_pkg::tsp_top_state_type n;
    logic scl_s;
    logic sda_s;
    logic scl_stuck;
    logic sda_stuck;
    logic mon_en;

    localparam int EV_W_L = tsp_pkg::EV_W;

    // ------------------------------------------------------------
    // Pin synchronisers and stuck-line monitors
    // ------------------------------------------------------------
    tsp_sync2 #(.RST_VAL(1'b1)) u_scl_sync (
        .clk(pclk), .rst_n(presetn), .d(scl_i), .q(scl_s)
    );
    tsp_sync2 #(.RST_VAL(1'b1)) u_sda_sync (
        .clk(pclk), .rst_n(presetn), .d(sda_i), .q(sda_s)
    );
    tsp_stuck_timer #(.LIMIT(STUCK_CYCLES_P)) u_scl_mon (
        .clk(pclk), .rst_n(presetn),
        .enable(mon_en), .line_low(!scl_s),
        .other_changed(sda_s != s.sda_q), .expired(scl_stuck)
    );
    tsp_stuck_timer #(.LIMIT(STUCK_CYCLES_P)) u_sda_mon (
        .clk(pclk), .rst_n(presetn),
        .enable(mon_en), .line_low(!sda_s),
        .other_changed(scl_s != s.scl_q), .expired(sda_stuck)
    );

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic nack_active;
    logic strap_done;

    // Bus conditions from synchronised levels
    assign scl_rise = scl_s && !s.scl_q;
    assign scl_fall = !scl_s && s.scl_q;
    assign start_c = scl_s && s.scl_q && s.sda_q && !sda_s;
    assign stop_c = scl_s && s.scl_q && !s.sda_q && sda_s;
    assign nack_active = (s.nack_cnt != '0);
    assign strap_done = (s.strap_cnt == tsp_pkg::STRAP_SETTLE);
    assign mon_en = strap_done && !s.standalone;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic apb_take;
        logic apb_done;
        logic soft_rst;
        logic bus_rst;
        logic load;
        logic rd_end;
        logic clr;
        logic chg_evt;
        logic [5:0] cur_keys;
        logic [EV_W_L-1:0] ev;
        n = s;
        apb_take = psel && penable && !s.pready;
        apb_done = psel && penable && s.pready;
        soft_rst = 1'b0;
        bus_rst = 1'b0;
        chg_evt = 1'b0;
        load = 1'b0;
        rd_end = 1'b0;
        clr = 1'b0;
        ev = '0;
        cur_keys = sense.keys & sense.key_mask;
        n.mem.wr = 1'b0;
        n.scl_q = scl_s;
        n.sda_q = sda_s;
        // Register reads, answered one cycle into the access phase
        n.pready = apb_take;
        n.pslverr = 1'b0;
        if (apb_take) begin
            n.prdata = 32'h0000_0000;
            case (paddr)
                tsp_pkg::OFF_CTRL: n.prdata[0] = s.lp;
                tsp_pkg::OFF_STATUS:
                    n.prdata[3:0] = {s.change, s.acquire, nack_active,
                                     s.standalone};
                tsp_pkg::OFF_INT_STATUS: n.prdata[3:0] = s.int_status;
                tsp_pkg::OFF_INT_MASK: n.prdata[3:0] = s.int_mask;
                tsp_pkg::OFF_POINTER: n.prdata[15:0] = {s.last_ptr, s.ptr};
                default: n.pslverr = 1'b1;
            endcase
        end
        // Register writes at the completing edge
        if (apb_done && pwrite) begin
            if (paddr == tsp_pkg::OFF_CTRL) begin
                n.lp = pwdata[tsp_pkg::CTRL_LP_BIT];
                soft_rst = pwdata[tsp_pkg::CTRL_SOFT_RST_BIT];
            end
            if (paddr == tsp_pkg::OFF_INT_MASK) begin
                n.int_mask = pwdata[3:0];
            end
        end
        if (apb_done && !pwrite && paddr == tsp_pkg::OFF_INT_STATUS) begin
            n.int_status = '0;
        end
        // Strap capture after reset release
        if (!strap_done) begin
            n.strap_cnt = s.strap_cnt + 3'h1;
            if (s.strap_cnt == tsp_pkg::STRAP_SETTLE - 3'h1) begin
                n.standalone = !sda_s && scl_s;
            end
        end
        // Soft reset opens the refusal window
        if (soft_rst) begin
            n.nack_cnt = tsp_pkg::CNT_W'(NACK_CYCLES_P);
        end else if (nack_active) begin
            n.nack_cnt = s.nack_cnt - 1'b1;
        end
        // Wake delay before acquisition
        if (s.lp && !n.lp) begin
            n.wake_cnt = tsp_pkg::CNT_W'(WAKE_CYCLES_P);
        end else if (!s.lp && s.wake_cnt != '0) begin
            n.wake_cnt = s.wake_cnt - 1'b1;
        end
        n.acquire = !s.lp && (s.wake_cnt == '0);
        // Serial protocol engine
        bus_rst = scl_stuck || sda_stuck || soft_rst;
        ev[tsp_pkg::EV_STUCK] = scl_stuck || sda_stuck;
        if (bus_rst || s.standalone || !strap_done) begin
            n.state = tsp_pkg::BUS_IDLE;
            n.sda_oe = 1'b0;
            rd_end = s.reading;
        end else if (start_c) begin
            n.state = tsp_pkg::BUS_RX;
            n.phase = tsp_pkg::PH_ADDR;
            n.cnt = 3'h0;
            n.full = 1'b0;
            n.sda_oe = 1'b0;
            rd_end = s.reading;
        end else if (stop_c) begin
            n.state = tsp_pkg::BUS_IDLE;
            n.sda_oe = 1'b0;
            rd_end = s.reading;
        end else begin
            case (s.state)
                tsp_pkg::BUS_RX: begin
                    if (scl_rise) begin
                        n.shift = {s.shift[6:0], sda_s};
                        n.cnt = s.cnt + 3'h1;
                        n.full = (s.cnt == 3'h7);
                    end else if (scl_fall && s.full) begin
                        n.full = 1'b0;
                        n.cnt = 3'h0;
                        n.state = tsp_pkg::BUS_RX_ACK;
                        n.sda_oe = 1'b1;
                        case (s.phase)
                            tsp_pkg::PH_ADDR: begin
                                if (s.shift[7:1] != tsp_pkg::SLAVE_ADDR ||
                                    nack_active) begin
                                    n.state = tsp_pkg::BUS_IDLE;
                                    n.sda_oe = 1'b0;
                                end else if (s.shift[0]) begin
                                    n.reading = 1'b1;
                                    n.seen_key = 1'b0;
                                    n.seen_inp = 1'b0;
                                end else begin
                                    n.phase = tsp_pkg::PH_PTR;
                                end
                            end
                            tsp_pkg::PH_PTR: begin
                                n.ptr = s.shift;
                                n.last_ptr = s.shift;
                                n.phase = tsp_pkg::PH_DATA;
                            end
                            default: begin
                                n.mem.wr = 1'b1;
                                n.mem.wdata = s.shift;
                                n.ptr = s.ptr + 8'h01;
                                ev[tsp_pkg::EV_WRITE] = 1'b1;
                            end
                        endcase
                    end
                end
                tsp_pkg::BUS_RX_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.state = tsp_pkg::BUS_RX;
                        load = s.reading;
                    end
                end
                tsp_pkg::BUS_TX: begin
                    if (scl_fall) begin
                        if (s.cnt == 3'h7) begin
                            n.state = tsp_pkg::BUS_TX_ACK;
                            n.sda_oe = 1'b0;
                        end else begin
                            n.shift = {s.shift[6:0], 1'b0};
                            n.cnt = s.cnt + 3'h1;
                            n.sda_oe = !s.shift[6];
                        end
                    end
                end
                tsp_pkg::BUS_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            n.state = tsp_pkg::BUS_IDLE;
                            rd_end = 1'b1;
                        end else begin
                            n.ptr = s.ptr + 8'h01;
                        end
                    end else if (scl_fall) begin
                        load = 1'b1;
                    end
                end
                default: n.state = tsp_pkg::BUS_IDLE;
            endcase
        end
        // Byte load for transmission, with status-read tracking
        if (load) begin
            n.state = tsp_pkg::BUS_TX;
            n.shift = mem_rdata;
            n.cnt = 3'h0;
            n.sda_oe = !mem_rdata[7];
            n.seen_key = s.seen_key || (s.ptr == tsp_pkg::KEY_STATUS_ADDR);
            n.seen_inp = s.seen_inp || (s.ptr == tsp_pkg::INPUT_STATUS_ADDR);
            clr = (n.seen_key && n.seen_inp) ||
                  (cur_keys == s.snap_keys && sense.inputs == s.snap_inp);
        end
        // Read end restores the pointer
        if (rd_end) begin
            n.reading = 1'b0;
            n.ptr = s.last_ptr;
            ev[tsp_pkg::EV_READ_END] = 1'b1;
        end
        n.mem.addr = n.mem.wr ? s.ptr : n.ptr;
        // Change line: set wins over clear
        chg_evt = (cur_keys != s.prev_keys) || (sense.inputs != s.prev_inp);
        n.prev_keys = cur_keys;
        n.prev_inp = sense.inputs;
        if (clr) begin
            n.change = 1'b0;
            n.snap_keys = cur_keys;
            n.snap_inp = sense.inputs;
        end
        if (chg_evt) begin
            n.change = 1'b1;
        end
        ev[tsp_pkg::EV_CHANGE] = chg_evt;
        n.int_status = n.int_status | ev;
        n.irq = |(n.int_status & s.int_mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.state <= tsp_pkg::BUS_IDLE;
            s.ptr <= tsp_pkg::PTR_RESET;
            s.last_ptr <= tsp_pkg::PTR_RESET;
            s.mem.addr <= tsp_pkg::PTR_RESET;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
            s.wake_cnt <= tsp_pkg::CNT_W'(WAKE_CYCLES_P);
            s.int_mask <= tsp_pkg::INT_MASK_RESET;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state; drive levels and scl_oe tied low
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign mem = s.mem;
    assign acquire_en = s.acquire;
    assign sda_oe = s.sda_oe;
    assign change_notify_line_oe = s.change;
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign scl_oe = 1'b0;
    assign change_notify_line_o = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_byte_in(tsp_pkg::tsp_phase_type ph);
        s.state == tsp_pkg::BUS_RX && s.phase == ph && s.full && scl_fall
        && !start_c && !stop_c && !scl_stuck && !sda_stuck && !s.standalone;
    endsequence

    AST_ADDR_MISS: assert property (
        seq_byte_in(tsp_pkg::PH_ADDR)
        ##0 (s.shift[7:1] != tsp_pkg::SLAVE_ADDR)
        |=> s.state == tsp_pkg::BUS_IDLE && !s.sda_oe)
        else $error("foreign address acknowledged");
    AST_PTR_ACK: assert property (
        seq_byte_in(tsp_pkg::PH_PTR)
        |=> s.sda_oe && s.ptr == $past(s.shift) && s.last_ptr == s.ptr)
        else $error("pointer byte not taken");
    AST_WRITE_STORE: assert property (
        seq_byte_in(tsp_pkg::PH_DATA)
        |=> s.mem.wr && s.mem.wdata == $past(s.shift)
            && s.mem.addr == $past(s.ptr) && s.ptr == $past(s.ptr) + 8'h01)
        else $error("data byte not stored");
    AST_READ_STEP: assert property (
        s.state == tsp_pkg::BUS_TX_ACK && scl_rise && !sda_s && !start_c
        && !stop_c && !scl_stuck && !sda_stuck && s.strap_cnt[2]
        |=> s.ptr == $past(s.ptr) + 8'h01)
        else $error("pointer did not step on ack");
    AST_NACK_END: assert property (
        s.state == tsp_pkg::BUS_TX_ACK && scl_rise && sda_s && !stop_c
        |=> s.state == tsp_pkg::BUS_IDLE ##1 !s.sda_oe)
        else $error("read went on after nack");
    AST_PTR_RESTORE: assert property (
        s.reading && !n.reading |=> s.ptr == $past(s.last_ptr))
        else $error("pointer not restored");
    AST_CHG_SET: assert property (
        ((sense.keys & sense.key_mask) != s.prev_keys
        || sense.inputs != s.prev_inp) |=> change_notify_line_oe)
        else $error("change line not pulled");
    AST_STUCK_RESET: assert property (
        scl_stuck || sda_stuck |=> s.state == tsp_pkg::BUS_IDLE && !sda_oe)
        else $error("bus logic not reset");
    AST_STANDALONE: assert property (
        s.standalone |-> !scl_stuck && !sda_stuck && !sda_oe)
        else $error("monitor active in standalone");
    AST_NACK_WINDOW: assert property (
        nack_active |-> !sda_oe)
        else $error("ack during refusal window");
    AST_WAKE_WAIT: assert property (
        $fell(s.lp) |-> !acquire_en [*8])
        else $error("acquisition before wake delay");
    AST_OPEN_DRAIN: assert property (
        !sda_o && !scl_o && !scl_oe && !change_notify_line_o)
        else $error("line driven high");
endmodule

/* File: verilog/tsp_pkg.sv */
package tsp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int STUCK_TIME_US = 14_000;
    localparam int STUCK_CYCLES = STUCK_TIME_US * CYC_PER_US;
    localparam int NACK_TIME_US = 30_000;
    localparam int NACK_CYCLES = NACK_TIME_US * CYC_PER_US;
    localparam int WAKE_TIME_US = 500;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CYC_PER_US;
    localparam int CNT_W = 20;
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    // ------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h12;
    localparam logic [7:0] KEY_STATUS_ADDR = 8'h04;
    localparam logic [7:0] INPUT_STATUS_ADDR = 8'h05;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_INT_STATUS = 8'h08;
    localparam logic [7:0] OFF_INT_MASK = 8'h0C;
    localparam logic [7:0] OFF_POINTER = 8'h10;
    localparam int CTRL_LP_BIT = 0;
    localparam int CTRL_SOFT_RST_BIT = 1;
    localparam int EV_WRITE = 0;
    localparam int EV_READ_END = 1;
    localparam int EV_STUCK = 2;
    localparam int EV_CHANGE = 3;
    localparam int EV_W = 4;
    localparam logic [EV_W-1:0] INT_MASK_RESET = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_RX, BUS_RX_ACK, BUS_TX, BUS_TX_ACK
    } tsp_bus_state_type;

    typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} tsp_phase_type;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tsp_mem_port_type;

    typedef struct packed {
        logic [5:0] key_mask;
        logic [5:0] keys;
        logic [6:0] inputs;
    } tsp_sense_type;

    typedef struct packed {
        tsp_bus_state_type state;
        tsp_phase_type phase;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic full;
        logic reading;
        logic sda_oe;
        logic [7:0] ptr;
        logic [7:0] last_ptr;
        tsp_mem_port_type mem;
        logic scl_q;
        logic sda_q;
        logic seen_key;
        logic seen_inp;
        logic change;
        logic [5:0] prev_keys;
        logic [6:0] prev_inp;
        logic [5:0] snap_keys;
        logic [6:0] snap_inp;
        logic [2:0] strap_cnt;
        logic standalone;
        logic [CNT_W-1:0] nack_cnt;
        logic lp;
        logic [CNT_W-1:0] wake_cnt;
        logic acquire;
        logic [EV_W-1:0] int_status;
        logic [EV_W-1:0] int_mask;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } tsp_top_state_type;

endpackage

/* File: verilog/tsp_sync2.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a pin level
module tsp_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic [1:0] s;
    logic [1:0] next_s;

    // ------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------
    always_comb begin
        next_s = {s[0], d};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= {2{RST_VAL}};
        end else begin
            s <= next_s;
        end
    end

    assign q = s[1];
endmodule

/* File: verilog/tsp_stuck_timer.sv */
`timescale 1ns/1ps
// Counts how long a line stays low with the other line quiet
module tsp_stuck_timer #(
    parameter int LIMIT = 280000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line observation
    input wire logic enable,
    input wire logic line_low,
    input wire logic other_changed,
    // One-cycle expiry pulse
    output logic expired
);
    typedef struct packed {
        logic [tsp_pkg::CNT_W-1:0] cnt;
        logic expired;
    } tsp_timer_state_type;

    tsp_timer_state_type s;
    tsp_timer_state_type next_s;

    // ------------------------------------------------------------
    // Counter, held at the limit so it fires once
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.expired = 1'b0;
        if (!enable || !line_low || other_changed) begin
            next_s.cnt = '0;
        end else if (s.cnt != tsp_pkg::CNT_W'(LIMIT)) begin
            next_s.cnt = s.cnt + 1'b1;
            next_s.expired = (s.cnt == tsp_pkg::CNT_W'(LIMIT - 1));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expired = s.expired;
endmodule

/* File: dv/tsp_host_model.sv */
`timescale 1ns/1ps
// Serial bus master, pulls lines low or releases them
module tsp_host_model (
    // Wire levels and pull-downs
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // Released lines at start
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Start or repeated start, leaves clock low
    task automatic start();
        #100 sda_low = 1'b0;
        #100 scl_low = 1'b0;
        #200 sda_low = 1'b1;
        #200 scl_low = 1'b1;
    endtask
    // Stop, clock stands still afterwards
    task automatic stop();
        #100 sda_low = 1'b1;
        #100 scl_low = 1'b0;
        #200 sda_low = 1'b0;
        #200;
    endtask
    // One bit, data moved mid low phase, 400 ns period
    task automatic bit_io(input logic b, output logic r);
        #100 sda_low = !b;
        #100 scl_low = 1'b0;
        #180 r = sda;
        #20 scl_low = 1'b1;
    endtask
    // Byte out MSB first, then ninth bit
    task automatic xfer(input logic [7:0] w, input logic nine,
        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], r[i]);
        end
        bit_io(nine, ack);
    endtask
endmodule

/* File: dv/tsp_slave_port_tb.sv */
`timescale 1ns/1ps
// Bench for the serial slave port
module tsp_slave_port_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, r, tbl [256];
    logic [31:0] pwdata, prdata, rd;
    logic scl_o, scl_oe, sda_o, sda_oe, nfy_o, nfy_oe, acq, scl_low;
    logic sda_low, a, e;
    tsp_pkg::tsp_mem_port_type mem;
    tsp_pkg::tsp_sense_type sense;
    int fails, samples_checked;
    wire logic scl = !(scl_low | scl_oe);
    wire logic sda = !(sda_low | sda_oe);
    wire logic [7:0] mem_rdata = tbl[mem.addr];
    tsp_slave_port #(.STUCK_CYCLES_P(200), .NACK_CYCLES_P(300),
        .WAKE_CYCLES_P(16)) u_tsp_slave_port (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .change_notify_line_o(nfy_o),
        .change_notify_line_oe(nfy_oe), .mem(mem), .mem_rdata(mem_rdata),
        .sense(sense), .acquire_en(acq));
    tsp_host_model u_tsp_host_model (.sda(sda), .scl_low(scl_low),
        .sda_low(sda_low));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Table behind the memory port
    always @(posedge pclk) begin
        if (mem.wr === 1'b1) tbl[mem.addr] <= mem.wdata;
    end
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
        samples_checked++;
        if (s !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic conclude();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // APB transfer, bounded wait on pready
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            conclude();
        end
    endtask
    // Pointer write with optional data bytes
    task automatic t_wr(input logic [7:0] p, input int n);
        u_tsp_host_model.start();
        u_tsp_host_model.xfer(8'h24, 1'b1, r, a);
        chk("addr ack", 8'h00, a);
        u_tsp_host_model.xfer(p, 1'b1, r, a);
        chk("ptr ack", 8'h00, a);
        for (int i = 0; i < n; i++) begin
            u_tsp_host_model.xfer(8'hA5 + 8'(i), 1'b1, r, a);
            chk("data ack", 8'h00, a);
        end
        u_tsp_host_model.stop();
        for (int i = 0; i < n; i++) chk("stored", 8'hA5 + 8'(i), tbl[p + 8'(i)]);
    endtask
    // Read of n bytes from base value x
    task automatic t_rd(input int n, input logic [7:0] x);
        u_tsp_host_model.start();
        u_tsp_host_model.xfer(8'h25, 1'b1, r, a);
        chk("read ack", 8'h00, a);
        for (int i = 0; i < n; i++) begin
            u_tsp_host_model.xfer(8'hFF, i == n - 1, r, a);
            chk("read byte", x + 8'(i), r);
        end
        u_tsp_host_model.stop();
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        sense = {6'h3F, 6'h00, 7'h00};
        fails = 0;
        samples_checked = 0;
        for (int i = 0; i < 256; i++) tbl[i] = 8'(i) ^ 8'h5A;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("acquire", 8'h01, acq);
        apb(1'b1, 8'h0C, 32'h8);
        t_wr(8'h10, 2);
        t_rd(2, 8'h12 ^ 8'h5A);
        t_rd(1, 8'hA5);
        u_tsp_host_model.start();
        u_tsp_host_model.xfer(8'h26, 1'b1, r, a);
        chk("foreign nack", 8'h01, a);
        u_tsp_host_model.stop();
        @(posedge pclk);
        sense.keys <= 6'h01;
        repeat (4) @(posedge pclk);
        chk("notify low", 8'h01, nfy_oe);
        chk("irq", 8'h01, irq);
        t_wr(8'h04, 0);
        t_rd(2, 8'h04 ^ 8'h5A);
        chk("notify free", 8'h00, nfy_oe);
        u_tsp_host_model.start();
        #15000;
        u_tsp_host_model.stop();
        apb(1'b0, 8'h08, 32'h0);
        chk("events", 8'h0F, rd[7:0]);
        repeat (2) @(posedge pclk);
        chk("irq clear", 8'h00, irq);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 8'h01, e);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        chk("wake hold", 8'h00, acq);
        repeat (20) @(posedge pclk);
        chk("wake done", 8'h01, acq);
        apb(1'b1, 8'h00, 32'h2);
        u_tsp_host_model.start();
        u_tsp_host_model.xfer(8'h24, 1'b1, r, a);
        chk("refusal", 8'h01, a);
        u_tsp_host_model.stop();
        conclude();
    end
endmodule
